// File: src/irq_priority_regs_wake_pins.sv
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// RL1 - Each word holds four 3-bit priority fields at bits 7:5, 15:13, 23:21, 31:29.
// RL2 - All other bits of every word ignore writes and read as zero.
// RL3 - Field value zero is the most urgent; larger values are less urgent.
// RL4 - Each source nominally has 32 levels, but only three bits are stored.
// RL5 - Seven words sit at consecutive word addresses 0xE000E404 through 0xE000E41C.
// RL6 - Words one to five cover port 0 pins 4-11, then port 1 pins 0-11.
// RL7 - Words six and seven cover port 2 pins 0-3 and 4-7.
// RL8 - Every implemented field clears to zero on reset.
module irq_priority_regs_wake_pins (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [31:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rdata,
  output logic [2:0] prio_port0_pin4,
  output logic [2:0] prio_port0_pin5,
  output logic [2:0] prio_port0_pin6,
  output logic [2:0] prio_port0_pin7,
  output logic [2:0] prio_port0_pin8,
  output logic [2:0] prio_port0_pin9,
  output logic [2:0] prio_port0_pin10,
  output logic [2:0] prio_port0_pin11,
  output logic [2:0] prio_port1_pin0,
  output logic [2:0] prio_port1_pin1,
  output logic [2:0] prio_port1_pin2,
  output logic [2:0] prio_port1_pin3,
  output logic [2:0] prio_port1_pin4,
  output logic [2:0] prio_port1_pin5,
  output logic [2:0] prio_port1_pin6,
  output logic [2:0] prio_port1_pin7,
  output logic [2:0] prio_port1_pin8,
  output logic [2:0] prio_port1_pin9,
  output logic [2:0] prio_port1_pin10,
  output logic [2:0] prio_port1_pin11,
  output logic [2:0] prio_port2_pin0,
  output logic [2:0] prio_port2_pin1,
  output logic [2:0] prio_port2_pin2,
  output logic [2:0] prio_port2_pin3,
  output logic [2:0] prio_port2_pin4,
  output logic [2:0] prio_port2_pin5,
  output logic [2:0] prio_port2_pin6,
  output logic [2:0] prio_port2_pin7
);

  localparam int unsigned NREG = irq_prio_pkg::NUM_REGS;
  localparam int unsigned NFLD = irq_prio_pkg::FIELDS_PER_REG;
  localparam int unsigned FW = irq_prio_pkg::FIELD_W;
  localparam int unsigned IW = irq_prio_pkg::IDX_W;

  typedef struct packed {
    logic [31:0] rdata;
  } bus_state_t;

  bus_state_t state_ff;
  bus_state_t nxt_state;

  logic rst_sync_n;
  logic [irq_prio_pkg::IDX_W-1:0] idx;
  logic hit;
  logic [NREG-1:0] word_wr;
  logic [NFLD-1:0][FW-1:0] fields [NREG];
  logic [31:0] rd_words [NREG];
  logic [NREG*NFLD*FW-1:0] all_fields;

  // Every word leaves reset on the same enabled edge, so none can take a write that its neighbours miss.
  rst_release u_rst_release (
    .clk(clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .rst_sync_n(rst_sync_n)
  );

  assign idx = irq_prio_pkg::reg_index(addr); // RL5
  // Addresses are decoded in full, so aliases of the seven words read as unmapped instead of wrapping.
  assign hit = (idx != irq_prio_pkg::IDX_NONE);

  for (genvar r = 0; r < NREG; r++) begin : g_word
    // Word r answers only to its own address; an unmapped write is dropped.
    assign word_wr[r] = wr_en && (idx == IW'(r)); // RL5

    prio_word #(
      .FIELDS(NFLD)
    ) u_word (
      .clk(clk),
      .rst_n(rst_sync_n),
      .clk_en(clk_en),
      .wr_en(word_wr[r]),
      .wdata(wdata),
      .fields(fields[r]),
      .rd_word(rd_words[r])
    );

    assign all_fields[r*NFLD*FW +: NFLD*FW] = fields[r];
  end

  // Read data appear for exactly one cycle after the read strobe, zero otherwise.
  always_comb begin
    nxt_state = state_ff;
    nxt_state.rdata = irq_prio_pkg::RDATA_IDLE;
    if (rd_en && hit) begin
      nxt_state.rdata = rd_words[idx[2:0]]; // RL2 RL5
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state_ff <= '0;
    end else if (clk_en) begin
      state_ff <= nxt_state;
    end
  end

  assign rdata = state_ff.rdata;

  // Lowest field of each word carries the lowest pin number.
  assign prio_port0_pin4 = fields[0][0]; // RL6
  assign prio_port0_pin5 = fields[0][1];
  assign prio_port0_pin6 = fields[0][2];
  assign prio_port0_pin7 = fields[0][3];
  assign prio_port0_pin8 = fields[1][0];
  assign prio_port0_pin9 = fields[1][1];
  assign prio_port0_pin10 = fields[1][2];
  assign prio_port0_pin11 = fields[1][3];
  assign prio_port1_pin0 = fields[2][0];
  assign prio_port1_pin1 = fields[2][1];
  assign prio_port1_pin2 = fields[2][2];
  assign prio_port1_pin3 = fields[2][3];
  assign prio_port1_pin4 = fields[3][0];
  assign prio_port1_pin5 = fields[3][1];
  assign prio_port1_pin6 = fields[3][2];
  assign prio_port1_pin7 = fields[3][3];
  assign prio_port1_pin8 = fields[4][0];
  assign prio_port1_pin9 = fields[4][1];
  assign prio_port1_pin10 = fields[4][2];
  assign prio_port1_pin11 = fields[4][3];
  assign prio_port2_pin0 = fields[5][0]; // RL7
  assign prio_port2_pin1 = fields[5][1];
  assign prio_port2_pin2 = fields[5][2];
  assign prio_port2_pin3 = fields[5][3];
  assign prio_port2_pin4 = fields[6][0];
  assign prio_port2_pin5 = fields[6][1];
  assign prio_port2_pin6 = fields[6][2];
  assign prio_port2_pin7 = fields[6][3];

  default clocking cb @(posedge clk);
  endclocking

  default disable iff (!rst_sync_n);

  sequence s_write_hit;
    clk_en && wr_en && hit;
  endsequence

  sequence s_read_same_addr;
    clk_en && rd_en && !wr_en && (addr == $past(addr));
  endsequence

  // A write followed at once by a read of the same word returns only the kept bits.
  property p_write_readback;
    s_write_hit ##1 s_read_same_addr |=> rdata == ($past(wdata, 2) & irq_prio_pkg::FIELD_MASK);
  endproperty
  a_write_readback: assert property (p_write_readback) else $error("read-back differs from written fields"); // RL1

  property p_reserved_zero;
    (rdata & ~irq_prio_pkg::FIELD_MASK) == 32'h00000000;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("unimplemented bit read as one"); // RL2

  property p_unmapped_zero;
    clk_en && rd_en && !hit |=> rdata == irq_prio_pkg::RDATA_IDLE;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read returned nonzero"); // RL5

  property p_read_one_cycle;
    clk_en && rd_en ##1 clk_en && !rd_en |=> rdata == irq_prio_pkg::RDATA_IDLE;
  endproperty
  a_read_one_cycle: assert property (p_read_one_cycle) else $error("read data held past one cycle"); // RL5

  property p_port0_map;
    clk_en && wr_en && addr == irq_prio_pkg::OFS_PORT0_PINS4_7 |=>
      (32'(prio_port0_pin4) << 5) == ($past(wdata) & 32'h000000E0) &&
      (32'(prio_port0_pin7) << 29) == ($past(wdata) & 32'hE0000000);
  endproperty
  a_port0_map: assert property (p_port0_map) else $error("port 0 pin field mapping wrong"); // RL6

  property p_port1_map;
    clk_en && wr_en && addr == irq_prio_pkg::OFS_PORT1_PINS8_11 |=>
      (32'(prio_port1_pin8) << 5) == ($past(wdata) & 32'h000000E0) &&
      (32'(prio_port1_pin11) << 29) == ($past(wdata) & 32'hE0000000);
  endproperty
  a_port1_map: assert property (p_port1_map) else $error("port 1 pin field mapping wrong"); // RL6

  property p_port2_read;
    clk_en && rd_en && addr == irq_prio_pkg::OFS_PORT2_PINS4_7 |=>
      rdata == {prio_port2_pin7, 5'h00, prio_port2_pin6, 5'h00, prio_port2_pin5, 5'h00, prio_port2_pin4, 5'h00};
  endproperty
  a_port2_read: assert property (p_port2_read) else $error("port 2 word read layout wrong"); // RL7

  property p_hold_without_write;
    !(clk_en && wr_en && hit) |=> $stable(all_fields);
  endproperty
  a_hold_without_write: assert property (p_hold_without_write) else $error("field changed without a write"); // RL1

  property p_freeze;
    !clk_en |=> $stable(rdata) && $stable(all_fields);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while clock enable low");

  property p_reset_zero;
    @(posedge clk) disable iff (1'b0)
      $rose(rst_sync_n) |-> all_fields == '0 && rdata == irq_prio_pkg::RDATA_IDLE;
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("fields not most urgent after reset"); // RL8 RL3

  // Picks field j out of a bus word; the same lane layout serves writes and reads.
  function automatic logic [FW-1:0] lane_of(input logic [31:0] word, input int unsigned j);
    return word[j*irq_prio_pkg::SLOT_W+irq_prio_pkg::FIELD_LSB0 +: FW];
  endfunction

  sequence s_write_at(logic [31:0] a);
    clk_en && wr_en && addr == a;
  endsequence

  sequence s_read_at(logic [31:0] a);
    clk_en && rd_en && addr == a;
  endsequence

  // A write lands at the edge that takes it, so the pins show it one cycle later.
  property p_port0_hi_map;
    s_write_at(irq_prio_pkg::OFS_PORT0_PINS8_11) |=>
      prio_port0_pin8 == lane_of($past(wdata), 0) && prio_port0_pin9 == lane_of($past(wdata), 1) &&
      prio_port0_pin10 == lane_of($past(wdata), 2) && prio_port0_pin11 == lane_of($past(wdata), 3);
  endproperty
  a_port0_hi_map: assert property (p_port0_hi_map) else $error("port 0 upper pin fields wrong"); // RL6

  property p_port1_lo_map;
    s_write_at(irq_prio_pkg::OFS_PORT1_PINS0_3) |=>
      prio_port1_pin0 == lane_of($past(wdata), 0) && prio_port1_pin1 == lane_of($past(wdata), 1) &&
      prio_port1_pin2 == lane_of($past(wdata), 2) && prio_port1_pin3 == lane_of($past(wdata), 3);
  endproperty
  a_port1_lo_map: assert property (p_port1_lo_map) else $error("port 1 lower pin fields wrong"); // RL6

  property p_port1_mid_map;
    s_write_at(irq_prio_pkg::OFS_PORT1_PINS4_7) |=>
      prio_port1_pin4 == lane_of($past(wdata), 0) && prio_port1_pin5 == lane_of($past(wdata), 1) &&
      prio_port1_pin6 == lane_of($past(wdata), 2) && prio_port1_pin7 == lane_of($past(wdata), 3);
  endproperty
  a_port1_mid_map: assert property (p_port1_mid_map) else $error("port 1 middle pin fields wrong"); // RL6

  property p_port2_lo_map;
    s_write_at(irq_prio_pkg::OFS_PORT2_PINS0_3) |=>
      prio_port2_pin0 == lane_of($past(wdata), 0) && prio_port2_pin1 == lane_of($past(wdata), 1) &&
      prio_port2_pin2 == lane_of($past(wdata), 2) && prio_port2_pin3 == lane_of($past(wdata), 3);
  endproperty
  a_port2_lo_map: assert property (p_port2_lo_map) else $error("port 2 lower pin fields wrong"); // RL7

  property p_port2_hi_map;
    s_write_at(irq_prio_pkg::OFS_PORT2_PINS4_7) |=>
      prio_port2_pin4 == lane_of($past(wdata), 0) && prio_port2_pin5 == lane_of($past(wdata), 1) &&
      prio_port2_pin6 == lane_of($past(wdata), 2) && prio_port2_pin7 == lane_of($past(wdata), 3);
  endproperty
  a_port2_hi_map: assert property (p_port2_hi_map) else $error("port 2 upper pin fields wrong"); // RL7

  property p_port0_read;
    s_read_at(irq_prio_pkg::OFS_PORT0_PINS4_7) |=>
      lane_of(rdata, 0) == prio_port0_pin4 && lane_of(rdata, 1) == prio_port0_pin5 &&
      lane_of(rdata, 2) == prio_port0_pin6 && lane_of(rdata, 3) == prio_port0_pin7;
  endproperty
  a_port0_read: assert property (p_port0_read) else $error("port 0 word read layout wrong"); // RL6

  // An unmapped or misaligned write must leave every word alone.
  property p_unmapped_write;
    clk_en && wr_en && !hit |=> $stable(all_fields);
  endproperty
  a_unmapped_write: assert property (p_unmapped_write) else $error("unmapped write changed a field"); // RL5

  // Idle cycles return zero, so a stray sample of rdata never looks like a live priority.
  property p_rdata_idle;
    clk_en && !rd_en |=> rdata == irq_prio_pkg::RDATA_IDLE;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data nonzero without a read");

  // Each word may change only on its own write, so a decode slip shows up at the word it hits.
  for (genvar r = 0; r < NREG; r++) begin : g_word_check
    property p_word_hold;
      !(clk_en && word_wr[r]) |=> $stable(fields[r]);
    endproperty
    a_word_hold: assert property (p_word_hold) else $error("priority word changed without its own write"); // RL5

    property p_word_read;
      clk_en && rd_en && idx == IW'(r) |=>
        lane_of(rdata, 0) == fields[r][0] && lane_of(rdata, 1) == fields[r][1] &&
        lane_of(rdata, 2) == fields[r][2] && lane_of(rdata, 3) == fields[r][3];
    endproperty
    a_word_read: assert property (p_word_read) else $error("priority word read lanes wrong"); // RL1 RL2
  end

endmodule

`default_nettype wire

// File: src/irq_prio_pkg.sv
package irq_prio_pkg;

  // Register file shape.
  localparam int unsigned NUM_REGS = 7;
  localparam int unsigned FIELDS_PER_REG = 4;
  localparam int unsigned FIELD_W = 3;
  localparam int unsigned LEVEL_W = 5;
  localparam int unsigned SLOT_W = 8;
  localparam int unsigned FIELD_LSB0 = 5;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned IDX_W = 4;

  // Byte addresses of the seven priority words.
  localparam logic [31:0] OFS_PORT0_PINS4_7 = 32'hE000E404;
  localparam logic [31:0] OFS_PORT0_PINS8_11 = 32'hE000E408;
  localparam logic [31:0] OFS_PORT1_PINS0_3 = 32'hE000E40C;
  localparam logic [31:0] OFS_PORT1_PINS4_7 = 32'hE000E410;
  localparam logic [31:0] OFS_PORT1_PINS8_11 = 32'hE000E414;
  localparam logic [31:0] OFS_PORT2_PINS0_3 = 32'hE000E418;
  localparam logic [31:0] OFS_PORT2_PINS4_7 = 32'hE000E41C;

  // Implemented bits are 31:29, 23:21, 15:13 and 7:5; all others read zero.
  localparam logic [31:0] FIELD_MASK = 32'hE0E0E0E0;
  localparam logic [31:0] RDATA_IDLE = 32'h00000000;
  localparam logic [2:0] FIELD_RESET = 3'h0;
  localparam logic [2:0] MOST_URGENT = 3'h0;
  localparam logic [4:0] PAD_BITS = 5'h00;
  localparam logic [3:0] IDX_NONE = 4'hF;

  typedef logic [FIELD_W-1:0] field_t;

  // Maps a byte address onto a word index, or IDX_NONE when unmapped.
  function automatic logic [IDX_W-1:0] reg_index(input logic [31:0] addr);
    logic [IDX_W-1:0] idx;
    idx = IDX_NONE;
    unique case (addr)
      OFS_PORT0_PINS4_7: idx = 4'h0;
      OFS_PORT0_PINS8_11: idx = 4'h1;
      OFS_PORT1_PINS0_3: idx = 4'h2;
      OFS_PORT1_PINS4_7: idx = 4'h3;
      OFS_PORT1_PINS8_11: idx = 4'h4;
      OFS_PORT2_PINS0_3: idx = 4'h5;
      OFS_PORT2_PINS4_7: idx = 4'h6;
      default: idx = IDX_NONE;
    endcase
    return idx;
  endfunction

endpackage

// File: src/rst_release.sv
`timescale 1ns/1ps
`default_nettype none

// Asserts asynchronously, releases after two enabled clock edges.
module rst_release (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  output logic rst_sync_n
);

  typedef struct packed {
    logic stage1;
    logic stage2;
  } sync_state_t;

  sync_state_t state_ff;
  sync_state_t nxt_state;

  always_comb begin
    nxt_state = state_ff;
    nxt_state.stage1 = 1'b1;
    nxt_state.stage2 = state_ff.stage1;
  end

  // The release also waits for the clock enable, so no flop leaves reset while frozen.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= '0;
    end else if (clk_en) begin
      state_ff <= nxt_state;
    end
  end

  assign rst_sync_n = state_ff.stage2;

endmodule

`default_nettype wire

// File: src/prio_word.sv
`timescale 1ns/1ps
`default_nettype none

// One priority word: four 3-bit fields, each in the top of its byte.
module prio_word #(
  parameter int unsigned FIELDS = irq_prio_pkg::FIELDS_PER_REG
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic wr_en,
  input wire logic [31:0] wdata,
  output logic [FIELDS-1:0][irq_prio_pkg::FIELD_W-1:0] fields,
  output logic [31:0] rd_word
);

  typedef struct packed {
    logic [FIELDS-1:0][irq_prio_pkg::FIELD_W-1:0] field;
  } word_state_t;

  word_state_t state_ff;
  word_state_t nxt_state;

  always_comb begin
    nxt_state = state_ff;
    if (wr_en) begin
      for (int i = 0; i < FIELDS; i++) begin
        // Only the implemented bits are taken; the rest of the byte is dropped.
        nxt_state.field[i] = wdata[i*irq_prio_pkg::SLOT_W+irq_prio_pkg::FIELD_LSB0 +: irq_prio_pkg::FIELD_W]; // RL1 RL2
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= '0; // RL8 RL3
    end else if (clk_en) begin
      state_ff <= nxt_state;
    end
  end

  assign fields = state_ff.field;

  for (genvar g = 0; g < FIELDS; g++) begin : g_slot
    // A field reads as the top of a 5-bit level with the two low bits absent.
    assign rd_word[g*irq_prio_pkg::SLOT_W +: irq_prio_pkg::SLOT_W] = {state_ff.field[g], irq_prio_pkg::PAD_BITS}; // RL2 RL4
  end

endmodule

`default_nettype wire

// File: testbench/irq_priority_regs_wake_pins_tb.sv
`timescale 1ns/1ps
`default_nettype none

module irq_priority_regs_wake_pins_tb;
  logic clk;
  logic rst_n;
  logic clk_en;
  logic [31:0] addr;
  logic [31:0] wdata;
  logic wr_en;
  logic rd_en;
  logic [31:0] rdata;
  wire logic [83:0] pa;
  logic [31:0] mdl [7];
  logic [31:0] bad_a [6];
  int err_total;
  int n_tests;

  irq_priority_regs_wake_pins uut (
    .clk(clk), .rst_n(rst_n), .clk_en(clk_en), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
    .rdata(rdata), .prio_port0_pin4(pa[2:0]), .prio_port0_pin5(pa[5:3]), .prio_port0_pin6(pa[8:6]),
    .prio_port0_pin7(pa[11:9]), .prio_port0_pin8(pa[14:12]), .prio_port0_pin9(pa[17:15]),
    .prio_port0_pin10(pa[20:18]), .prio_port0_pin11(pa[23:21]), .prio_port1_pin0(pa[26:24]),
    .prio_port1_pin1(pa[29:27]), .prio_port1_pin2(pa[32:30]), .prio_port1_pin3(pa[35:33]),
    .prio_port1_pin4(pa[38:36]), .prio_port1_pin5(pa[41:39]), .prio_port1_pin6(pa[44:42]),
    .prio_port1_pin7(pa[47:45]), .prio_port1_pin8(pa[50:48]), .prio_port1_pin9(pa[53:51]),
    .prio_port1_pin10(pa[56:54]), .prio_port1_pin11(pa[59:57]), .prio_port2_pin0(pa[62:60]),
    .prio_port2_pin1(pa[65:63]), .prio_port2_pin2(pa[68:66]), .prio_port2_pin3(pa[71:69]),
    .prio_port2_pin4(pa[74:72]), .prio_port2_pin5(pa[77:75]), .prio_port2_pin6(pa[80:78]),
    .prio_port2_pin7(pa[83:81])
  );

  // Only aligned words from the first to the seventh priority address are mapped.
  function automatic int word_of(input logic [31:0] a);
    if (a[1:0] == 2'h0 && a >= 32'hE000E404 && a <= 32'hE000E41C) begin
      return int'((a - 32'hE000E404) >> 2);
    end
    return -1;
  endfunction

  function automatic logic [31:0] exp_read(input logic [31:0] a);
    int k;
    k = word_of(a);
    if (k < 0) begin
      return 32'h00000000;
    end
    return mdl[k];
  endfunction

  task automatic drive(input logic w, input logic r, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    wr_en <= w;
    rd_en <= r;
    addr <= a;
    wdata <= d;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    int k;
    k = word_of(a);
    drive(1'b1, 1'b0, a, d);
    if (k >= 0) begin
      mdl[k] = d & 32'hE0E0E0E0;
    end
  endtask

  task automatic rd(input logic [31:0] a);
    logic [31:0] e;
    drive(1'b0, 1'b1, a, 32'h00000000);
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    e = exp_read(a);
    n_tests++;
    if (rdata !== e) begin
      err_total++;
      $display("BAD %0t read %h got %h want %h", $time, a, rdata, e);
    end
  endtask

  // Lane j of word k must sit at bits 8j+7:8j+5; rdata must be back at zero when idle.
  task automatic check_fields();
    drive(1'b0, 1'b0, addr, wdata);
    #1;
    n_tests++;
    if (rdata !== 32'h00000000) begin
      err_total++;
      $display("BAD %0t idle read data %h", $time, rdata);
    end
    for (int k = 0; k < 7; k++) begin
      for (int j = 0; j < 4; j++) begin
        n_tests++;
        if (pa[(k*4+j)*3 +: 3] !== mdl[k][8*j+5 +: 3]) begin
          err_total++;
          $display("BAD %0t word %0d field %0d got %h", $time, k, j, pa[(k*4+j)*3 +: 3]);
        end
      end
    end
  endtask

  task automatic do_reset();
    @(posedge clk);
    rst_n <= 1'b0;
    wr_en <= 1'b0;
    rd_en <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    for (int k = 0; k < 7; k++) begin
      mdl[k] = 32'h00000000;
    end
  endtask

  task automatic complete_run();
    if (err_total == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    repeat (100000) @(posedge clk);
    err_total++;
    complete_run();
  end

  initial begin
    logic [31:0] r;
    logic [2:0] lv;
    rst_n = 1'b0;
    clk_en = 1'b1;
    addr = 32'h00000000;
    wdata = 32'h00000000;
    wr_en = 1'b0;
    rd_en = 1'b0;
    err_total = 0;
    n_tests = 0;
    bad_a = '{32'hE000E400, 32'hE000E420, 32'hE000E405, 32'hE000E40E, 32'hE000E41F, 32'h0000E404};
    void'($urandom(7705));
    do_reset();
    check_fields();
    for (int k = 0; k < 7; k++) rd(32'hE000E404 + 32'(4 * k));
    // Unimplemented bits are written as ones so that leaking lanes show up.
    for (int v = 0; v < 8; v++) begin
      lv = 3'(v);
      for (int k = 0; k < 7; k++) begin
        wr(32'hE000E404 + 32'(4 * k), {4{lv, 5'h1F}});
        rd(32'hE000E404 + 32'(4 * k));
      end
      check_fields();
    end
    for (int k = 0; k < 7; k++) begin
      wr(32'hE000E404 + 32'(4 * k), {3'(k + 3), 5'h0A, 3'(k + 2), 5'h15, 3'(k + 1), 5'h0A, 3'(k), 5'h15});
    end
    check_fields();
    for (int i = 0; i < 6; i++) begin
      wr(bad_a[i], 32'hFFFFFFFF);
      rd(bad_a[i]);
    end
    check_fields();
    @(posedge clk);
    clk_en <= 1'b0;
    wr_en <= 1'b1;
    addr <= 32'hE000E404;
    wdata <= 32'h1F1F1F1F;
    @(posedge clk);
    wr_en <= 1'b0;
    clk_en <= 1'b1;
    check_fields();
    repeat (400) begin
      r = $urandom;
      addr <= addr;
      if (r[3:0] < 4'hC) begin
        wr(32'hE000E404 + 32'(4 * (r[7:4] % 7)), $urandom);
      end else begin
        rd(bad_a[r[7:4] % 6]);
      end
      if (r[8]) rd(32'hE000E404 + 32'(4 * (r[12:9] % 7)));
      if (r[15:13] == 3'h0) check_fields();
    end
    do_reset();
    check_fields();
    for (int k = 0; k < 7; k++) rd(32'hE000E404 + 32'(4 * k));
    complete_run();
  end
endmodule

`default_nettype wire
